// ---- rtl/ctu_cam_cmd.sv ----
// Behaviour
// - opcodes 60H and 76H search using preloaded key, segment and mask
// - 61H sets every empty bit and clears every usage bit
// - 62H empties entries with usage clear, then clears all usage bits
// - 63H empties entries with usage set, then clears all usage bits
// - 64H, when match status shows a match, empties entry at match pointer and clears its usage bit
// - 65H empties entry at direct pointer and clears its usage bit
// - 66H clears all usage bits, nothing else
// - 74H/73H empty matched entries with usage clear/set, then clear usage
// - 75H clears usage bits of matched entries only
// - 67H steps match pointer to next hit, updates status and pins
// - 68H returns match pointer, status and pins to post-search state
// - 69H steps free pointer to next empty, updates status and full pin
// - free confirm rescans for first empty, updates status and full pin
// - 6CH writes last key into entry at free pointer, making it valid, unless the free status bit is set
// - 6EH appends then advances free pointer like next free
// - 6DH clears empty bit of entry at direct pointer
// - 70H stamps key into segment at direct pointer, masked bits kept
// - 77H stamps second key with second mask, masked bits kept
// - writing the opcode register starts the command
// - with internal arbitration and auto switch set, append enters combined mode
`timescale 1ns/10ps
`default_nettype none
`include "ctu_regs.svh"

module ctu_cam_cmd (
   input  wire logic                     i_clk_sys,
   input  wire logic                     i_arst_n,
   input  wire ctu_pkg::ctu_apb_req_type i_apb,
   input  wire logic                     i_int_arb,
   output logic [31:0]                   o_prdata,
   output logic                          o_pready,
   output logic                          o_pslverr,
   output logic                          o_single_match_n,
   output logic                          o_multiple_match_n,
   output logic                          o_table_full_n,
   output logic                          o_iop_mode
);

   localparam int NE = `CTU_ENTRIES;

   logic [31:0]               tbl_ff [NE][`CTU_SEGS];
   logic [NE-1:0]             empty_ff;
   logic [NE-1:0]             usage_ff;
   logic [NE-1:0]             hit_ff;
   logic [31:0]               key_ff;
   logic [31:0]               mask_ff;
   logic [31:0]               key_b_ff;
   logic [31:0]               mask_b_ff;
   logic                      segsel_ff;
   logic                      segsel_b_ff;
   logic [7:0]                segctl_ff;
   logic [`CTU_ADDR_W-1:0]    direct_ff;
   logic [31:0]               last_key_ff;
   logic                      last_seg_ff;
   logic [`CTU_IDX_W-1:0]     match_ff;
   logic [1:0]                mstat_ff;
   logic [`CTU_IDX_W-1:0]     free_ff;
   logic                      fstat_ff;
   ctu_pkg::ctu_mode_type     mode_ff;
   logic [31:0]               prdata_ff;

   // lowest set bit at or above start; start past the top finds nothing
   function automatic ctu_pkg::ctu_scan_type scan_from(input logic [NE-1:0] vec,
                                                       input logic [4:0] start);
      ctu_pkg::ctu_scan_type r;
      r = '0;
      for (int i = NE - 1; i >= 0; i--) begin
         if (vec[i] && (5'(i) >= start)) begin
            r.found = 1'b1;
            r.idx   = 4'(i);
         end
      end
      return r;
   endfunction

   // masked bits of the old word survive the stamp
   function automatic logic [31:0] merge(input logic [31:0] old_w,
                                         input logic [31:0] new_w,
                                         input logic [31:0] msk);
      return (old_w & msk) | (new_w & ~msk);
   endfunction

   // bus decode: writes take effect on the access edge only
   logic wr_go;
   logic rd_setup;
   logic cmd_go;
   logic addr_ok;
   logic [7:0] op;
   assign wr_go    = i_apb.psel & i_apb.penable & i_apb.pwrite;
   assign rd_setup = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
   assign cmd_go   = wr_go && (i_apb.paddr == `CTU_OFF_OPCODE);
   assign op       = i_apb.pwdata[7:0];

   always_comb begin
      case (i_apb.paddr)
         `CTU_OFF_OPCODE, `CTU_OFF_KEY, `CTU_OFF_MASK, `CTU_OFF_SEGSEL,
         `CTU_OFF_KEY_B, `CTU_OFF_MASK_B, `CTU_OFF_SEGCTL, `CTU_OFF_DIRECT,
         `CTU_OFF_MATCH, `CTU_OFF_FREE, `CTU_OFF_MSTAT, `CTU_OFF_FSTAT,
         `CTU_OFF_MODE, `CTU_OFF_SEGSEL_B: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // zero wait state slave; read data was captured in the setup cycle
   assign o_pready  = i_apb.psel & i_apb.penable;
   assign o_pslverr = o_pready & ~addr_ok;
   assign o_prdata  = prdata_ff;

   // command strobes
   logic is_lookup;
   logic is_lookup_b;
   logic is_add;
   logic is_add_adv;
   assign is_lookup   = cmd_go && (op == `CTU_OP_LOOKUP);
   assign is_lookup_b = cmd_go && (op == `CTU_OP_LOOKUP_B);
   assign is_add      = cmd_go && (op == `CTU_OP_ADD);
   assign is_add_adv  = cmd_go && (op == `CTU_OP_ADD_ADV);

   // search compare against the host settings loaded beforehand
   logic [NE-1:0] cmp_vec;
   always_comb begin
      cmp_vec = '0;
      for (int i = 0; i < NE; i++) begin
         cmp_vec[i] = ~empty_ff[i] &&
                      (((tbl_ff[i][segsel_ff] ^ key_ff) & ~mask_ff) == 32'h0000_0000);
      end
   end

   logic [`CTU_IDX_W-1:0] direct_idx;
   assign direct_idx = direct_ff[`CTU_ADDR_W-1:1];

   // host registers and the last key used by a search
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         key_ff      <= 32'h0000_0000;
         mask_ff     <= 32'h0000_0000;
         key_b_ff    <= 32'h0000_0000;
         mask_b_ff   <= 32'h0000_0000;
         segsel_ff   <= 1'b0;
         segsel_b_ff <= 1'b0;
         segctl_ff   <= 8'h00;
         direct_ff   <= '0;
         last_key_ff <= 32'h0000_0000;
         last_seg_ff <= 1'b0;
      end else begin
         if (wr_go) begin
            case (i_apb.paddr)
               `CTU_OFF_KEY:      key_ff      <= i_apb.pwdata;
               `CTU_OFF_MASK:     mask_ff     <= i_apb.pwdata;
               `CTU_OFF_KEY_B:    key_b_ff    <= i_apb.pwdata;
               `CTU_OFF_MASK_B:   mask_b_ff   <= i_apb.pwdata;
               `CTU_OFF_SEGSEL:   segsel_ff   <= i_apb.pwdata[0];
               `CTU_OFF_SEGSEL_B: segsel_b_ff <= i_apb.pwdata[0];
               `CTU_OFF_SEGCTL:   segctl_ff   <= i_apb.pwdata[7:0];
               `CTU_OFF_DIRECT:   direct_ff   <= i_apb.pwdata[`CTU_ADDR_W-1:0];
               default: ;
            endcase
         end
         if (is_lookup || is_lookup_b) begin
            last_key_ff <= key_ff;
            last_seg_ff <= segsel_ff;
         end
      end
   end

   // table contents: append and segment stamps
   always_ff @(posedge i_clk_sys) begin
      if ((is_add || is_add_adv) && !fstat_ff) begin
         tbl_ff[free_ff][last_seg_ff] <= last_key_ff;
      end
      if (cmd_go && (op == `CTU_OP_STAMP)) begin
         tbl_ff[direct_idx][segctl_ff[`CTU_SEGCTL_STSEG]] <=
            merge(tbl_ff[direct_idx][segctl_ff[`CTU_SEGCTL_STSEG]], key_ff, mask_ff);
      end
      if (cmd_go && (op == `CTU_OP_STAMP_B)) begin
         tbl_ff[direct_idx][segsel_b_ff] <=
            merge(tbl_ff[direct_idx][segsel_b_ff], key_b_ff, mask_b_ff);
      end
   end

   // match flags hold the result of the most recent search
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hit_ff <= '0;
      end else if (is_lookup || is_lookup_b) begin
         hit_ff <= cmp_vec;
      end
   end

   // empty bits; reset leaves the whole table empty
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         empty_ff <= '1;
      end else if (cmd_go) begin
         case (op)
            `CTU_OP_INV_ALL:     empty_ff <= '1;
            `CTU_OP_DROP_UNUSED: empty_ff <= empty_ff | ~usage_ff;
            `CTU_OP_DROP_USED:   empty_ff <= empty_ff | usage_ff;
            `CTU_OP_DROP_UN_M:   empty_ff <= empty_ff | (hit_ff & ~usage_ff);
            `CTU_OP_DROP_US_M:   empty_ff <= empty_ff | (hit_ff & usage_ff);
            `CTU_OP_DROP_MATCH: begin
               if (mstat_ff[0]) begin
                  empty_ff[match_ff] <= 1'b1;
               end
            end
            `CTU_OP_DROP_DIRECT: empty_ff[direct_idx] <= 1'b1;
            `CTU_OP_RESTORE:     empty_ff[direct_idx] <= 1'b0;
            `CTU_OP_ADD, `CTU_OP_ADD_ADV: begin
               if (!fstat_ff) begin
                  empty_ff[free_ff] <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // usage bits; a search may mark its hits when the mark bit is set
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         usage_ff <= '0;
      end else if (cmd_go) begin
         case (op)
            `CTU_OP_INV_ALL, `CTU_OP_DROP_UNUSED, `CTU_OP_DROP_USED,
            `CTU_OP_DROP_UN_M, `CTU_OP_DROP_US_M,
            `CTU_OP_CLR_USAGE: usage_ff <= '0;
            `CTU_OP_CLR_USE_M: usage_ff <= usage_ff & ~hit_ff;
            `CTU_OP_DROP_MATCH: begin
               if (mstat_ff[0]) begin
                  usage_ff[match_ff] <= 1'b0;
               end
            end
            `CTU_OP_DROP_DIRECT: usage_ff[direct_idx] <= 1'b0;
            `CTU_OP_LOOKUP, `CTU_OP_LOOKUP_B: begin
               if (segctl_ff[`CTU_SEGCTL_MARK]) begin
                  usage_ff <= usage_ff | cmp_vec;
               end
            end
            default: ;
         endcase
      end
   end

   // match pointer walk; purges leave it and the match flags stale until the next search
   ctu_pkg::ctu_scan_type m_first;
   ctu_pkg::ctu_scan_type m_second;
   ctu_pkg::ctu_scan_type m_next;
   ctu_pkg::ctu_scan_type m_after;
   ctu_pkg::ctu_scan_type r_first;
   ctu_pkg::ctu_scan_type r_second;
   assign m_first  = scan_from(cmp_vec, 5'h00);
   assign m_second = scan_from(cmp_vec, {1'b0, m_first.idx} + 5'h01);
   assign m_next   = scan_from(hit_ff, {1'b0, match_ff} + 5'h01);
   assign m_after  = scan_from(hit_ff, {1'b0, m_next.idx} + 5'h01);
   assign r_first  = scan_from(hit_ff, 5'h00);
   assign r_second = scan_from(hit_ff, {1'b0, r_first.idx} + 5'h01);

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         match_ff <= '0;
         mstat_ff <= 2'h0;
      end else if (is_lookup || is_lookup_b) begin
         match_ff <= m_first.idx;
         mstat_ff <= {m_first.found & m_second.found, m_first.found};
      end else if (cmd_go && (op == `CTU_OP_NEXT_MATCH)) begin
         if (m_next.found) begin
            match_ff <= m_next.idx;
         end
         mstat_ff <= {m_next.found & m_after.found, m_next.found};
      end else if (cmd_go && (op == `CTU_OP_MATCH_RET)) begin
         match_ff <= r_first.idx;
         mstat_ff <= {r_first.found & r_second.found, r_first.found};
      end
   end

   // free pointer; status bit set means the last scan found no empty entry at or above its start
   ctu_pkg::ctu_scan_type f_next;
   ctu_pkg::ctu_scan_type f_first;
   assign f_next  = scan_from(empty_ff, {1'b0, free_ff} + 5'h01);
   assign f_first = scan_from(empty_ff, 5'h00);

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         free_ff  <= '0;
         fstat_ff <= 1'b0;
      end else if (cmd_go && ((op == `CTU_OP_NEXT_FREE) || (op == `CTU_OP_ADD_ADV))) begin
         if (f_next.found) begin
            free_ff <= f_next.idx;
         end
         fstat_ff <= ~f_next.found;
      end else if (cmd_go && (op == `CTU_OP_FREE_CONF)) begin
         free_ff  <= f_first.idx;
         fstat_ff <= ~f_first.found;
      end
   end

   // mode: software writes the mode register to return to cpu mode
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         mode_ff <= ctu_pkg::CTU_MODE_CPU;
      end else if ((is_add || is_add_adv) && i_int_arb && segctl_ff[`CTU_SEGCTL_AUTOSW]) begin
         mode_ff <= ctu_pkg::CTU_MODE_IOP;
      end else if (wr_go && (i_apb.paddr == `CTU_OFF_MODE)) begin
         mode_ff <= i_apb.pwdata[0] ? ctu_pkg::CTU_MODE_IOP : ctu_pkg::CTU_MODE_CPU;
      end
   end

   // read data is latched in setup so the access phase sees a flop
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_setup) begin
         case (i_apb.paddr)
            `CTU_OFF_KEY:      prdata_ff <= key_ff;
            `CTU_OFF_MASK:     prdata_ff <= mask_ff;
            `CTU_OFF_KEY_B:    prdata_ff <= key_b_ff;
            `CTU_OFF_MASK_B:   prdata_ff <= mask_b_ff;
            `CTU_OFF_SEGSEL:   prdata_ff <= {31'h0000_0000, segsel_ff};
            `CTU_OFF_SEGSEL_B: prdata_ff <= {31'h0000_0000, segsel_b_ff};
            `CTU_OFF_SEGCTL:   prdata_ff <= {24'h00_0000, segctl_ff};
            `CTU_OFF_DIRECT:   prdata_ff <= {27'h000_0000, direct_ff};
            `CTU_OFF_MATCH:    prdata_ff <= {27'h000_0000, match_ff, 1'b0};
            `CTU_OFF_FREE:     prdata_ff <= {27'h000_0000, free_ff, 1'b0};
            `CTU_OFF_MSTAT:    prdata_ff <= {30'h0000_0000, mstat_ff};
            `CTU_OFF_FSTAT:    prdata_ff <= {31'h0000_0000, fstat_ff};
            `CTU_OFF_MODE:     prdata_ff <= {31'h0000_0000, mode_ff == ctu_pkg::CTU_MODE_IOP};
            default:           prdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   // status pins are active low and follow the status flops
   assign o_single_match_n   = ~mstat_ff[0];
   assign o_multiple_match_n = ~mstat_ff[1];
   assign o_table_full_n     = ~fstat_ff;
   assign o_iop_mode         = (mode_ff == ctu_pkg::CTU_MODE_IOP);

endmodule
`default_nettype wire

// ---- rtl/ctu_pkg.sv ----
`default_nettype none
package ctu_pkg;
   // apb request as driven by the master
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } ctu_apb_req_type;

   // port mode of the device
   typedef enum logic {
      CTU_MODE_CPU,
      CTU_MODE_IOP
   } ctu_mode_type;

   // result of a priority scan
   typedef struct packed {
      logic       found;
      logic [3:0] idx;
   } ctu_scan_type;
endpackage
`default_nettype wire

// ---- rtl/ctu_regs.svh ----
`ifndef CTU_REGS_SVH
`define CTU_REGS_SVH
// table geometry
`define CTU_ENTRIES        16
`define CTU_IDX_W          4
`define CTU_SEGS           2
`define CTU_ADDR_W         5
// register byte offsets
`define CTU_OFF_OPCODE     8'h00
`define CTU_OFF_KEY        8'h04
`define CTU_OFF_MASK       8'h08
`define CTU_OFF_SEGSEL     8'h0C
`define CTU_OFF_KEY_B      8'h10
`define CTU_OFF_MASK_B     8'h14
`define CTU_OFF_SEGCTL     8'h18
`define CTU_OFF_DIRECT     8'h1C
`define CTU_OFF_MATCH      8'h20
`define CTU_OFF_FREE       8'h24
`define CTU_OFF_MSTAT      8'h28
`define CTU_OFF_FSTAT      8'h2C
`define CTU_OFF_MODE       8'h30
`define CTU_OFF_SEGSEL_B   8'h34
// host_segment_ctl_reg fields
`define CTU_SEGCTL_AUTOSW  0
`define CTU_SEGCTL_MARK    1
`define CTU_SEGCTL_STSEG   4
// opcodes
`define CTU_OP_LOOKUP      8'h60
`define CTU_OP_LOOKUP_B    8'h76
`define CTU_OP_INV_ALL     8'h61
`define CTU_OP_DROP_UNUSED 8'h62
`define CTU_OP_DROP_USED   8'h63
`define CTU_OP_DROP_MATCH  8'h64
`define CTU_OP_DROP_DIRECT 8'h65
`define CTU_OP_CLR_USAGE   8'h66
`define CTU_OP_DROP_UN_M   8'h74
`define CTU_OP_DROP_US_M   8'h73
`define CTU_OP_CLR_USE_M   8'h75
`define CTU_OP_NEXT_MATCH  8'h67
`define CTU_OP_MATCH_RET   8'h68
`define CTU_OP_NEXT_FREE   8'h69
`define CTU_OP_FREE_CONF   8'h6B
`define CTU_OP_ADD         8'h6C
`define CTU_OP_ADD_ADV     8'h6E
`define CTU_OP_RESTORE     8'h6D
`define CTU_OP_STAMP       8'h70
`define CTU_OP_STAMP_B     8'h77
`endif

// ---- testbench/ctu_cam_cmd_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctu_cam_cmd_sva (
   input wire logic                     i_clk_sys,
   input wire logic                     i_arst_n,
   input wire ctu_pkg::ctu_apb_req_type i_apb,
   input wire logic                     i_int_arb,
   input wire logic [31:0]              o_prdata,
   input wire logic                     o_pready,
   input wire logic                     o_pslverr,
   input wire logic                     o_single_match_n,
   input wire logic                     o_multiple_match_n,
   input wire logic                     o_table_full_n,
   input wire logic                     o_iop_mode
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);

   logic       acc;
   logic       cmd_wr;
   logic       mode_wr;
   logic       bit0;
   logic       bad_addr;
   logic [7:0] op;

   // decoded host traffic; every command is a write of the opcode word
   assign acc      = i_apb.psel && i_apb.penable;
   assign cmd_wr   = acc && i_apb.pwrite && (i_apb.paddr == 8'h00);
   assign mode_wr  = acc && i_apb.pwrite && (i_apb.paddr == 8'h30);
   assign bit0     = i_apb.pwdata[0];
   assign bad_addr = (i_apb.paddr > 8'h34) || (i_apb.paddr[1:0] != 2'h0);
   assign op       = i_apb.pwdata[7:0];

   zero_wait_a: assert property (o_pready == acc)
      else $error("pready does not follow the access phase");
   slverr_map_a: assert property (o_pslverr == (acc && bad_addr))
      else $error("slave error does not match the address map");
   match_src_a: assert property ($changed(o_single_match_n) || $changed(o_multiple_match_n)
      |-> $past(cmd_wr) && ($past(op) inside {8'h60, 8'h76, 8'h67, 8'h68}))
      else $error("match pins moved without a match command");
   multi_only_a: assert property (!o_multiple_match_n |-> !o_single_match_n)
      else $error("multiple match shown without a match");
   full_src_a: assert property ($changed(o_table_full_n)
      |-> $past(cmd_wr) && ($past(op) inside {8'h69, 8'h6B, 8'h6E}))
      else $error("full pin moved without a free command");
   iop_rise_a: assert property ($rose(o_iop_mode) |-> $past(mode_wr) || ($past(cmd_wr)
      && $past(i_int_arb) && ($past(op) inside {8'h6C, 8'h6E})))
      else $error("combined mode entered without cause");
   iop_fall_a: assert property ($fell(o_iop_mode) |-> $past(mode_wr) && !$past(bit0))
      else $error("combined mode left without a mode write");
   empty_search_a: assert property (cmd_wr && op == 8'h61 ##3 cmd_wr && op == 8'h60
      |=> o_single_match_n && o_multiple_match_n)
      else $error("search hit on an invalidated table");
   confirm_free_a: assert property (cmd_wr && op == 8'h61 ##3 cmd_wr && op == 8'h6B
      |=> o_table_full_n)
      else $error("table full after invalidate and confirm");

   walk_c: cover property (cmd_wr && op == 8'h67 ##1 !o_multiple_match_n);
   full_c: cover property ($fell(o_table_full_n));
   iop_c: cover property ($rose(o_iop_mode));
   refuse_c: cover property (o_pslverr);
endmodule
`default_nettype wire

// ---- testbench/ctu_cam_cmd_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module ctu_cam_cmd_tb;
   logic                     i_clk_sys;
   logic                     i_arst_n;
   logic                     i_int_arb;
   ctu_pkg::ctu_apb_req_type i_apb;
   logic [31:0]              o_prdata;
   logic                     o_pready, o_pslverr, o_iop_mode;
   logic                     o_single_match_n, o_multiple_match_n, o_table_full_n;
   int                       failures = 0;
   int                       comparisons = 0;
   logic [31:0]              seed = 32'h0000ECB9;
   logic [31:0]              keys [16];
   logic [31:0]              exp_q [$];
   string                    name_q [$];
   logic [31:0]              ka, kb;
   localparam logic [31:0]   all_m = 32'hFFFFFFFF;

   ctu_cam_cmd dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_apb(i_apb),
      .i_int_arb(i_int_arb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .o_single_match_n(o_single_match_n), .o_multiple_match_n(o_multiple_match_n),
      .o_table_full_n(o_table_full_n), .o_iop_mode(o_iop_mode));
   ctu_host_model host (.i_clk_sys(i_clk_sys), .i_pready(o_pready), .o_apb(i_apb));

   // 100 MHz system clock
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end

   // xorshift keeps keys reproducible from the fixed start value
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d);
   endtask

   task automatic cmd(input logic [7:0] op);
      wr(8'h00, {24'h000000, op});
   endtask

   // the expectation is queued first; the monitor compares it when the read lands
   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      name_q.push_back(n);
      exp_q.push_back(e);
      host.xfer(1'b0, a, 32'h00000000);
   endtask

   task automatic look(input logic [3:0] idx, input logic [1:0] st);
      if (st[0]) rd("match entry", 8'h20, {27'h0, idx, 1'b0});
      rd("match status", 8'h28, {30'h0, st});
      chk("single pin", {31'h0, o_single_match_n}, {31'h0, ~st[0]});
      chk("multiple pin", {31'h0, o_multiple_match_n}, {31'h0, ~st[1]});
   endtask

   task automatic host_lookup_cmd(input logic [31:0] k, input logic [31:0] m, input logic [3:0] idx,
                       input logic [1:0] st);
      wr(8'h04, k);
      wr(8'h08, m);
      cmd(8'h60);
      look(idx, st);
   endtask

   // usage marking by searches is only switched on around setup searches
   task automatic mark(input logic b);
      wr(8'h18, b ? 32'h2 : 32'h0);
   endtask

   task automatic rst_ent(input logic [3:0] e);
      wr(8'h1C, {27'h0, e, 1'b0});
      cmd(8'h6D);
   endtask

   task automatic print_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // every finished read is matched with the oldest queued expectation
   always @(posedge i_clk_sys) begin
      if (i_apb.psel && i_apb.penable && !i_apb.pwrite && o_pready)
         chk(name_q.pop_front(), o_prdata, exp_q.pop_front());
   end

   // hang guard, far beyond the thousand or so cycles the tests need
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      failures++;
      print_verdict();
   end

   initial begin
      i_arst_n <= 1'b0;
      i_int_arb <= 1'b0;
      repeat (10) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      @(posedge i_clk_sys);
      rd("free status", 8'h2C, 32'h0);
      rd("mode", 8'h30, 32'h0);
      rd("unmapped", 8'h40, 32'h0);
      look(4'h0, 2'h0);
      cmd(8'h61);
      cmd(8'h6B);
      chk("full pin", {31'h0, o_table_full_n}, 32'h1);
      rd("free entry", 8'h24, 32'h0);
      $display("test reset done");
      for (int e = 0; e < 16; e++) begin
         keys[e] = rnd();
         keys[e][3:0] = e[3:0];
         host_lookup_cmd(keys[e], 32'h0, 4'h0, 2'h0);
         cmd(8'h6E);
         if (e < 15) rd("free entry", 8'h24, {27'h0, 4'(e + 1), 1'b0});
      end
      rd("free status", 8'h2C, 32'h1);
      chk("full pin", {31'h0, o_table_full_n}, 32'h0);
      cmd(8'h69);
      rd("free entry", 8'h24, 32'h1E);
      host_lookup_cmd(keys[5], 32'h0, 4'h5, 2'h1);
      // an append on a full table must not overwrite the entry at the free pointer
      cmd(8'h6C);
      host_lookup_cmd(keys[15], 32'h0, 4'hF, 2'h1);
      wr(8'h04, keys[9]);
      cmd(8'h76);
      look(4'h9, 2'h1);
      $display("test fill done");
      host_lookup_cmd(32'h1, 32'hFFFFFFFE, 4'h1, 2'h3);
      for (int j = 1; j < 8; j++) begin
         cmd(8'h67);
         look(4'(2 * j + 1), (j < 7) ? 2'h3 : 2'h1);
      end
      cmd(8'h67);
      look(4'h0, 2'h0);
      rd("match entry", 8'h20, 32'h1E);
      cmd(8'h68);
      look(4'h1, 2'h3);
      $display("test walk done");
      mark(1'b1);
      host_lookup_cmd(32'h1, 32'hFFFFFFFE, 4'h1, 2'h3);
      mark(1'b0);
      cmd(8'h63);
      host_lookup_cmd(32'h0, all_m, 4'h0, 2'h3);
      cmd(8'h6B);
      rd("free entry", 8'h24, 32'h2);
      cmd(8'h69);
      rd("free entry", 8'h24, 32'h6);
      mark(1'b1);
      host_lookup_cmd(keys[4], 32'h0, 4'h4, 2'h1);
      mark(1'b0);
      cmd(8'h62);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h1);
      cmd(8'h63);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h1);
      rst_ent(4'h6);
      rst_ent(4'h8);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h3);
      cmd(8'h64);
      host_lookup_cmd(32'h0, all_m, 4'h6, 2'h3);
      wr(8'h1C, 32'hC);
      cmd(8'h65);
      host_lookup_cmd(32'h0, all_m, 4'h8, 2'h1);
      rst_ent(4'h4);
      rst_ent(4'h6);
      mark(1'b1);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h3);
      mark(1'b0);
      cmd(8'h66);
      cmd(8'h63);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h3);
      mark(1'b1);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h3);
      mark(1'b0);
      host_lookup_cmd(keys[6], 32'h0, 4'h6, 2'h1);
      cmd(8'h75);
      cmd(8'h63);
      host_lookup_cmd(32'h0, all_m, 4'h6, 2'h1);
      rst_ent(4'h4);
      rst_ent(4'h8);
      mark(1'b1);
      host_lookup_cmd(keys[4], 32'h0, 4'h4, 2'h1);
      mark(1'b0);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h3);
      cmd(8'h74);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h1);
      mark(1'b1);
      host_lookup_cmd(32'h0, all_m, 4'h4, 2'h1);
      mark(1'b0);
      rst_ent(4'h8);
      cmd(8'h73);
      host_lookup_cmd(32'h0, all_m, 4'h8, 2'h1);
      $display("test purge done");
      ka = rnd();
      kb = rnd();
      cmd(8'h61);
      cmd(8'h60);
      rst_ent(4'h2);
      wr(8'h18, 32'h10);
      wr(8'h04, ka);
      wr(8'h08, 32'h0);
      cmd(8'h70);
      wr(8'h10, kb);
      wr(8'h14, 32'hFFFF0000);
      wr(8'h34, 32'h1);
      cmd(8'h77);
      wr(8'h0C, 32'h1);
      host_lookup_cmd({ka[31:16], kb[15:0]}, 32'h0, 4'h2, 2'h1);
      host_lookup_cmd({ka[31:16], ~kb[15:0]}, 32'h0, 4'h0, 2'h0);
      wr(8'h0C, 32'h0);
      $display("test stamp done");
      cmd(8'h6B);
      rd("free entry", 8'h24, 32'h0);
      i_int_arb <= 1'b1;
      wr(8'h18, 32'h1);
      ka = rnd();
      host_lookup_cmd(ka, 32'h0, 4'h0, 2'h0);
      cmd(8'h6C);
      chk("mode pin", {31'h0, o_iop_mode}, 32'h1);
      rd("mode", 8'h30, 32'h1);
      wr(8'h30, 32'h0);
      host_lookup_cmd(ka, 32'h0, 4'h0, 2'h1);
      i_int_arb <= 1'b0;
      cmd(8'h6C);
      chk("mode pin", {31'h0, o_iop_mode}, 32'h0);
      $display("test add done");
      print_verdict();
   end
endmodule

bind ctu_cam_cmd ctu_cam_cmd_sva sva (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_apb(i_apb),
   .i_int_arb(i_int_arb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .o_single_match_n(o_single_match_n), .o_multiple_match_n(o_multiple_match_n),
   .o_table_full_n(o_table_full_n), .o_iop_mode(o_iop_mode));
`default_nettype wire

// ---- testbench/ctu_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// apb master in the host's place; a single device, so every command is also selected
module ctu_host_model (
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_pready,
   output var ctu_pkg::ctu_apb_req_type o_apb
);
   initial o_apb = '0;

   // one transfer, held until pready is seen at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] dat);
      o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: adr, pwdata: dat};
      @(posedge i_clk_sys);
      o_apb.penable <= 1'b1;
      do @(posedge i_clk_sys); while (i_pready !== 1'b1);
      // released lines carry junk so the slave cannot lean on stale values
      o_apb <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~adr, pwdata: ~dat};
      @(posedge i_clk_sys);
   endtask
endmodule
`default_nettype wire
